// [design/aos_pkg.sv]
/*
  package for the analog output scaling block: register map, field
  layout, reset values, fixed-point limits and timing constants.
  assumes percent values held in hundredths, signed, 16 bits wide.
*/
package aos_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // fixed point and limits
  localparam int unsigned VAL_W = 16;
  localparam logic signed [15:0] PCT_100 = 16'sh2710;
  localparam logic signed [15:0] SET_MAX = 16'sh7530;
  localparam logic signed [15:0] SET_MIN = -16'sh7530;
  localparam logic signed [15:0] OUT_MAX = 16'sh2710;
  localparam logic signed [15:0] OUT_MIN = -16'sh2710;
  localparam logic signed [15:0] CUR_LOW = 16'sh07d0;
  localparam logic signed [15:0] ZERO = 16'sh0000;

  // ==========================================================
  // channel count and timing
  localparam int unsigned NUM_BASE = 3;
  localparam int unsigned NUM_OPT = 2;
  localparam int unsigned NUM_CH = NUM_BASE + NUM_OPT;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================
  // register map
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_DEMAND = 8'h00;
  localparam logic [7:0] OFS_GAIN = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] STATUS_BASE = 8'h80;
  localparam logic [7:0] STATUS_STRIDE = 8'h04;
  localparam logic [7:0] TICK_COUNT_ADDR = 8'ha0;

  // control field layout
  localparam int unsigned CTRL_MAG_BIT = 0;
  localparam int unsigned CTRL_RANGE_LSB = 1;

  // ==========================================================
  // output range codes
  typedef enum logic [1:0] {
    AOS_BIPOLAR_10V,
    AOS_UNIPOLAR_10V,
    AOS_CURRENT_0_20,
    AOS_CURRENT_4_20
  } aos_range_t;

  typedef struct packed {
    logic magnitude_select;
    aos_range_t range;
    logic signed [15:0] demand;
    logic signed [15:0] gain;
    logic signed [15:0] offset;
  } aos_cfg_t;

  // reset values
  localparam logic signed [15:0] RST_DEMAND = 16'sh0000;
  localparam logic signed [15:0] RST_GAIN = 16'sh2710;
  localparam logic signed [15:0] RST_OFFSET = 16'sh0000;
  localparam logic [4:0] RST_RANGE_UNIPOLAR = 5'h03;

  // ==========================================================
  // saturate a wide signed value into a setting span
  function automatic logic signed [15:0] aos_sat(
    input logic signed [31:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    if (v > 32'(hi)) begin
      return hi;
    end else if (v < 32'(lo)) begin
      return lo;
    end
    return v[15:0];
  endfunction : aos_sat

endpackage : aos_pkg

// [design/aos_chan.sv]
/*
  one analog output channel datapath, combinational: gain, offset,
  clamp, magnitude or range limit, converter mapping.
  assumes settings already saturated; parameters say which range
  codes the channel supports.
*/
module aos_chan #(
  parameter bit BIPOLAR_OK = 1'b1,
  parameter bit UNIPOLAR_OK = 1'b1,
  parameter bit CURRENT_OK = 1'b1
) (
  // settings
  input aos_pkg::aos_cfg_t cfg,
  input wire logic fitted,
  // result
  output logic signed [15:0] drive_code
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // datapath
  logic signed [31:0] product;
  logic signed [31:0] scaled;
  logic signed [31:0] summed;
  logic signed [15:0] clamped;
  logic signed [15:0] limited;
  logic supported;

  always_comb begin
    product = 32'(cfg.demand) * 32'(cfg.gain);
    scaled = product / 32'(aos_pkg::PCT_100);
    summed = scaled + 32'(cfg.offset);
    clamped = aos_pkg::aos_sat(summed, aos_pkg::OUT_MIN,
                               aos_pkg::OUT_MAX);
    if (cfg.magnitude_select) begin
      limited = (clamped < aos_pkg::ZERO) ? -clamped : clamped;
    end else if (cfg.range == aos_pkg::AOS_BIPOLAR_10V) begin
      limited = clamped;
    end else begin
      limited = (clamped < aos_pkg::ZERO) ? aos_pkg::ZERO : clamped;
    end
    case (cfg.range)
      aos_pkg::AOS_BIPOLAR_10V: supported = BIPOLAR_OK;
      aos_pkg::AOS_UNIPOLAR_10V: supported = UNIPOLAR_OK;
      aos_pkg::AOS_CURRENT_0_20: supported = CURRENT_OK;
      aos_pkg::AOS_CURRENT_4_20: supported = CURRENT_OK;
      default: supported = 1'b0;
    endcase
    if (!fitted || !supported) begin
      drive_code = aos_pkg::ZERO;
    end else if (cfg.range == aos_pkg::AOS_CURRENT_4_20) begin
      drive_code = 16'(32'(aos_pkg::CUR_LOW) +
                       (32'(limited) * 32'sd4) / 32'sd5);
    end else begin
      drive_code = limited;
    end
  end

endmodule : aos_chan

// [design/aos_top.sv]
/*
  analog output scaling for three base and two option-card channels,
  with a plain register port and registered converter drive codes.
  assumes a synchronous 200 MHz clock and synchronous inputs.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
// Contract
// - output is demand times gain over 100 percent, plus offset
// - gain of 100 percent passes the demand unchanged
// - offset is added after gain; zero offset changes nothing
// - magnitude select true drives absolute value of the result
// - magnitude select false limits result to the selected range
// - range codes: 0 bipolar 10V, 1 0-10V, 2 0-20mA, 3 4-20mA
// - result clamped to plus or minus 100 percent
// - plus 100 percent maps to +10V, minus 100 to -10V
// - unsupported range code holds the channel at zero volts
// - first base channel takes every range but bipolar; second and third take all four
// - unipolar first channel drives zero for negative demand
// - option cards add two channels with range codes 0 and 1 only
// - every channel recomputed once per 1 ms tick
// - values delivered into settings clamped to their limits
module aos_top #(
  parameter int unsigned TICK_CYCLES = aos_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // option cards fitted
  input wire logic [1:0] card_fitted,
  // converter drive, 10000 = full scale
  output logic signed [15:0] drive_code [aos_pkg::NUM_CH],
  output logic tick
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned NCH = aos_pkg::NUM_CH;

  // ==========================================================
  // elaboration check
  generate
    if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00ffffff) begin : g_bad
      $error("tick cycle count out of range");
    end
  endgenerate

  // ==========================================================
  // settings registers
  aos_pkg::aos_cfg_t cfg_reg [NCH];
  aos_pkg::aos_cfg_t cfg_next [NCH];
  logic signed [15:0] wval;

  always_comb begin
    wval = aos_pkg::aos_sat(wr_data, aos_pkg::SET_MIN,
                            aos_pkg::SET_MAX);
    for (int c = 0; c < NCH; c++) begin
      cfg_next[c] = cfg_reg[c];
      if (wr_en && addr[7:4] == 4'(c)) begin
        case (addr[3:0])
          aos_pkg::OFS_DEMAND[3:0]: cfg_next[c].demand = wval;
          aos_pkg::OFS_GAIN[3:0]: cfg_next[c].gain = wval;
          aos_pkg::OFS_OFFSET[3:0]: cfg_next[c].offset = wval;
          aos_pkg::OFS_CTRL[3:0]: begin
            cfg_next[c].magnitude_select =
              wr_data[aos_pkg::CTRL_MAG_BIT];
            cfg_next[c].range = aos_pkg::aos_range_t'(
              wr_data[aos_pkg::CTRL_RANGE_LSB +: 2]);
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rst_n) begin
        cfg_reg[c].demand <= aos_pkg::RST_DEMAND;
        cfg_reg[c].gain <= aos_pkg::RST_GAIN;
        cfg_reg[c].offset <= aos_pkg::RST_OFFSET;
        cfg_reg[c].magnitude_select <= 1'b0;
        cfg_reg[c].range <= aos_pkg::RST_RANGE_UNIPOLAR[c] ?
          aos_pkg::AOS_UNIPOLAR_10V : aos_pkg::AOS_BIPOLAR_10V;
      end else begin
        cfg_reg[c] <= cfg_next[c];
      end
    end
  end

  // ==========================================================
  // execution tick
  logic [23:0] tick_cnt_reg;
  logic [23:0] tick_cnt_next;
  logic tick_next;

  always_comb begin
    if (tick_cnt_reg == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_next = 24'h000000;
      tick_next = 1'b1;
    end else begin
      tick_cnt_next = tick_cnt_reg + 24'h000001;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_reg <= 24'h000000;
      tick <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick <= tick_next;
    end
  end

  // ==========================================================
  // channel datapaths
  logic signed [15:0] chan_code [NCH];
  logic [NCH-1:0] fitted;

  assign fitted = {card_fitted, 3'h7};

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      aos_chan #(
        .BIPOLAR_OK(c != 0),
        .UNIPOLAR_OK(1'b1),
        .CURRENT_OK(c < aos_pkg::NUM_BASE)
      ) u_chan (
        .cfg(cfg_reg[c]),
        .fitted(fitted[c]),
        .drive_code(chan_code[c])
      );
    end
  endgenerate

  // ==========================================================
  // drive outputs, refreshed on the tick
  logic signed [15:0] drive_next [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      drive_next[c] = tick_next ? chan_code[c] : drive_code[c];
    end
  end

  always_ff @(posedge clock) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rst_n) begin
        drive_code[c] <= aos_pkg::ZERO;
      end else begin
        drive_code[c] <= drive_next[c];
      end
    end
  end

  // ==========================================================
  // read port
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h00000000;
    if (rd_en) begin
      if (addr == aos_pkg::TICK_COUNT_ADDR) begin
        rd_next = {8'h00, tick_cnt_reg};
      end
      for (int c = 0; c < NCH; c++) begin
        if (addr[7:4] == 4'(c)) begin
          case (addr[3:0])
            aos_pkg::OFS_DEMAND[3:0]:
              rd_next = 32'(cfg_reg[c].demand);
            aos_pkg::OFS_GAIN[3:0]:
              rd_next = 32'(cfg_reg[c].gain);
            aos_pkg::OFS_OFFSET[3:0]:
              rd_next = 32'(cfg_reg[c].offset);
            aos_pkg::OFS_CTRL[3:0]:
              rd_next = {29'h00000000, cfg_reg[c].range,
                         cfg_reg[c].magnitude_select};
            default: rd_next = 32'h00000000;
          endcase
        end
        if (addr == aos_pkg::STATUS_BASE + 8'(c * 4)) begin
          rd_next = 32'(drive_code[c]);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= rd_next;
    end
  end

endmodule : aos_top

// [verif/aos_conv_model.sv]
/*
  converter electronics model: turns drive codes into output levels.
  assumes one code step is one millivolt (or 2 uA on current ranges).
*/
module aos_conv_model (
  // drive codes from the block
  input wire logic signed [15:0] code [aos_pkg::NUM_CH],
  // output level per channel
  output logic signed [31:0] mv [aos_pkg::NUM_CH]
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // code to level
  always_comb begin
    for (int i = 0; i < aos_pkg::NUM_CH; i++) begin
      mv[i] = 32'(code[i]);
    end
  end
endmodule : aos_conv_model

// [verif/aos_top_asserts.sv]
/*
  checker for aos_top, bound to its ports.
  assumes control writes land at ch1 0x1c and ch3 0x3c.
*/
module aos_top_asserts #(
  parameter int unsigned TICK_CYCLES = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // drive side
  input wire logic [1:0] card_fitted,
  input wire logic signed [15:0] drive_code [aos_pkg::NUM_CH],
  input wire logic tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========
  // shadow control and tick gap
  logic [2:0] c1_reg;
  logic [2:0] c3_reg;
  logic [31:0] gap_reg;
  logic seen_reg;
  logic [79:0] flat;
  assign flat = {drive_code[4], drive_code[3], drive_code[2],
    drive_code[1], drive_code[0]};
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      c1_reg <= 3'h2;
      c3_reg <= 3'h0;
      gap_reg <= 32'h0;
      seen_reg <= 1'b0;
    end else begin
      if (wr_en && addr == 8'h1c) c1_reg <= wr_data[2:0];
      if (wr_en && addr == 8'h3c) c3_reg <= wr_data[2:0];
      gap_reg <= tick ? 32'h0 : gap_reg + 32'h1;
      if (tick) seen_reg <= 1'b1;
    end
  end
  // ==========
  // properties
  property p_clamp;
    drive_code[2] <= aos_pkg::OUT_MAX && drive_code[2] >= aos_pkg::OUT_MIN;
  endproperty
  property p_ch0;
    drive_code[0] >= 0;
  endproperty
  property p_unfit;
    tick && !$past(card_fitted[1]) |-> drive_code[4] == 0;
  endproperty
  property p_hold;
    !tick |-> $stable(flat);
  endproperty
  property p_pulse;
    tick |=> !tick;
  endproperty
  property p_gap;
    tick && seen_reg |-> gap_reg == TICK_CYCLES - 1;
  endproperty
  property p_cur;
    tick && $past(c1_reg) == 3'h6 |-> drive_code[1] >= 16'sh07d0;
  endproperty
  property p_unsup;
    tick && $past(c3_reg[2]) |-> drive_code[3] == 0;
  endproperty
  property p_mag;
    tick && $past(c1_reg[0]) |-> drive_code[1] >= 0;
  endproperty
  property p_uni;
    tick && $past(c1_reg) == 3'h2 |-> drive_code[1] >= 0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
  a_ch0: assert property (p_ch0) else $error("ch0 neg");
  a_unfit: assert property (p_unfit) else $error("unfit");
  a_hold: assert property (p_hold) else $error("hold");
  a_pulse: assert property (p_pulse) else $error("pulse");
  a_gap: assert property (p_gap) else $error("gap");
  a_cur: assert property (p_cur) else $error("4-20");
  a_unsup: assert property (p_unsup) else $error("unsup");
  a_mag: assert property (p_mag) else $error("mag");
  a_uni: assert property (p_uni) else $error("uni");
  c_tick: cover property (tick);
  c_rd: cover property (rd_en ##1 rd_data != 0);
  c_cur: cover property (tick && $past(c1_reg) == 3'h6);
endmodule : aos_top_asserts
bind aos_top aos_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .card_fitted(card_fitted), .drive_code(drive_code), .tick(tick));

// [verif/aos_top_test.sv]
/*
  testbench for aos_top: random settings, expected levels per tick.
  assumes a short tick period and the converter model.
*/
module aos_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0;
  logic rst_n = 0;
  logic wr_en = 0;
  logic rd_en = 0;
  logic pr = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic [1:0] card_fitted = 2'h3;
  logic signed [15:0] drive_code [aos_pkg::NUM_CH];
  logic tick;
  logic signed [31:0] mv [aos_pkg::NUM_CH];
  logic [31:0] seed = 32'd55219;
  logic [31:0] rq[$];
  logic [31:0] dq[$];
  int n_mismatch = 0;
  int compares = 0;
  aos_top #(.TICK_CYCLES(16)) u_dut (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .card_fitted(card_fitted),
    .drive_code(drive_code), .tick(tick));
  aos_conv_model u_conv (.code(drive_code), .mv(mv));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // ==========
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int ex(int d, int g, int o, int c, int ch, int f);
    int s;
    s = d * g / 10000 + o;
    s = s > 10000 ? 10000 : (s < -10000 ? -10000 : s);
    if ((ch == 0 && c < 2) || (ch > 2 && (c > 3 || f == 0))) return 0;
    if (c % 2 == 1) s = s < 0 ? -s : s;
    else if (c > 1 && s < 0) s = 0;
    return c / 2 == 3 ? 2000 + s * 4 / 5 : s;
  endfunction : ex
  task wr(input logic [7:0] a, input int d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
  endtask : rd
  task wt;
    do @(negedge clock); while (tick !== 1'b1);
  endtask : wt
  task chk_rd(input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD rd_data expected %h seen %h", e, s);
    end
  endtask : chk_rd
  task chk_lvl(input int c, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD level%0d expected %h seen %h", c, e, s);
    end
  endtask : chk_lvl
  task end_of_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // ==========
  // monitor
  always @(negedge clock) begin
    if (pr) chk_rd(rq.pop_front(), rd_data);
    pr = rd_en;
    if (tick === 1'b1 && dq.size() > 0) begin
      for (int c = 0; c < 5; c++) chk_lvl(c, dq.pop_front(), mv[c]);
    end
  end
  // ==========
  // stimulus
  initial begin
    int d, g, o, k;
    logic [1:0] cf;
    int e [5];
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      cf = 2'(xs());
      @(posedge clock);
      card_fitted <= cf;
      for (int c = 0; c < 5; c++) begin
        d = $signed(xs()) % 30001;
        g = i < 4 ? 10000 : $signed(xs()) % 30001;
        o = i < 4 ? 0 : $signed(xs()) % 30001;
        k = xs() % 8;
        wr(8'(c * 16), d);
        wr(8'(c * 16 + 4), g);
        wr(8'(c * 16 + 8), o);
        wr(8'(c * 16 + 12), k);
        e[c] = ex(d, g, o, k, c, c < 3 ? 1 : cf[c - 3]);
      end
      wt();
      @(posedge clock);
      for (int c = 0; c < 5; c++) dq.push_back(32'(e[c]));
      wt();
    end
    for (int c = 0; c < 5; c++) rd(8'h80 + 8'(c * 4), 32'(e[c]));
    wr(8'h2c, 32'h000000ff);
    rd(8'h2c, 32'h00000007);
    wr(8'h04, 40000);
    rd(8'h04, 32'd30000);
    rd(8'hf0, 32'h0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h04, 32'd10000);
    rd(8'ha0, 32'h00000003);
    repeat (3) @(posedge clock);
    end_of_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule : aos_top_test
